/* hdl/lcr_lane_regs.sv */
// lane conditioning register bank with lane control outputs
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module lcr_lane_regs
   import lcr_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire lcr_bus_req_t i_bus,
   output logic [7:0] o_rdata,
   input wire lcr_strap_t i_strap,
   input wire logic i_signal_present,
   input wire logic i_rate_detected_5g,
   output lcr_lane_ctrl_t o_lane_ctrl
);

   ////////////////////////////////////////////////////////////////////////////
   // storage and decode

   logic [7:0] regs_q [LCR_NUM_REGS];
   logic [LCR_NUM_REGS-1:0] hit;
   logic strap_done_q;
   logic strap_load;
   logic [5:0] strap_eq_code;
   logic strap_eq_valid;
   logic [7:0] strap_deemph_code;
   logic strap_deemph_valid;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   lcr_lane_ctrl_t ctrl_d;
   lcr_lane_ctrl_t ctrl_q;

   // strap pins translated to register codes
   lcr_strap_decode u_strap_decode (
      .i_strap(i_strap),
      .o_eq_code(strap_eq_code),
      .o_eq_valid(strap_eq_valid),
      .o_deemph_code(strap_deemph_code),
      .o_deemph_valid(strap_deemph_valid)
   );

   // straps are sampled once, on the first edge after reset release
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
      end
   end

   assign strap_load = !strap_done_q;

   ////////////////////////////////////////////////////////////////////////////
   // register entries

   generate
      for (genvar g = 0; g < LCR_NUM_REGS; g++) begin : g_reg
         assign hit[g] = (i_bus.addr == LCR_ADDR_TBL[g]);

         // bus write stores only defined bits; strap load seeds eq and deemph
         always_ff @(posedge i_sys_clk) begin
            if (!i_reset_n) begin
               regs_q[g] <= LCR_RST_TBL[g];
            end else if (i_bus.wr && hit[g]) begin
               regs_q[g] <= i_bus.wdata & LCR_MASK_TBL[g];
            end else if (strap_load && (g == LCR_IDX_EQ) && strap_eq_valid) begin
               regs_q[g] <= {2'h0, strap_eq_code};
            end else if (strap_load && (g == LCR_IDX_DEEMPH) && strap_deemph_valid) begin
               regs_q[g] <= strap_deemph_code;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read port: data stands in the cycle after the read strobe only

   always_comb begin
      rdata_d = 8'h00;
      if (i_bus.rd) begin
         for (int k = 0; k < LCR_NUM_REGS; k++) begin
            if (hit[k]) begin
               rdata_d = regs_q[k];
            end
         end
      end
   end

   // unmapped reads answer zero
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // lane control decode from the register fields

   always_comb begin
      // quiet handling: detector runs only in automatic mode
      ctrl_d.detector_enable = regs_q[LCR_IDX_DETECT][LCR_QUIET_AUTO_BIT];
      if (regs_q[LCR_IDX_DETECT][LCR_QUIET_AUTO_BIT]) begin
         ctrl_d.output_muted = !i_signal_present;
      end else begin
         ctrl_d.output_muted = regs_q[LCR_IDX_DETECT][LCR_QUIET_SEL_BIT];
      end
      // rate: automatic follows the detector, else forced by select bit
      ctrl_d.rate_auto = regs_q[LCR_IDX_DETECT][LCR_RATE_AUTO_BIT];
      if (regs_q[LCR_IDX_DETECT][LCR_RATE_AUTO_BIT]) begin
         ctrl_d.rate_5g = i_rate_detected_5g;
      end else begin
         ctrl_d.rate_5g = regs_q[LCR_IDX_DETECT][LCR_RATE_SEL_BIT];
      end
      // equalizer fields, bypass when enable alone is set
      ctrl_d.eq_enable = regs_q[LCR_IDX_EQ][LCR_EQ_EN_BIT];
      ctrl_d.gain_stage_field = regs_q[LCR_IDX_EQ][LCR_EQ_GAIN_HI:LCR_EQ_GAIN_LO];
      ctrl_d.boost_level_field = regs_q[LCR_IDX_EQ][LCR_EQ_BOOST_HI:LCR_EQ_BOOST_LO];
      // swing code passes straight to the driver
      ctrl_d.output_swing_field = regs_q[LCR_IDX_SWING][LCR_SWING_HI:0];
      // de-emphasis style and level
      ctrl_d.deemphasis_style = regs_q[LCR_IDX_DEEMPH][LCR_DEEMPH_STYLE_BIT];
      ctrl_d.deemph_level = regs_q[LCR_IDX_DEEMPH][LCR_DEEMPH_LEVEL_HI:0];
      // quiet detector thresholds
      ctrl_d.quiet_deassert_thr =
         regs_q[LCR_IDX_THRESH][LCR_THR_DEASSERT_HI:LCR_THR_DEASSERT_LO];
      ctrl_d.quiet_assert_thr =
         regs_q[LCR_IDX_THRESH][LCR_THR_ASSERT_HI:LCR_THR_ASSERT_LO];
   end

   // lane controls are registered so the analog side sees glitch-free levels
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         ctrl_q <= '0;
         ctrl_q.eq_enable <= 1'b1;
         ctrl_q.output_swing_field <= LCR_SWING_600MV;
         ctrl_q.deemph_level <= LCR_RST_DEEMPH[LCR_DEEMPH_LEVEL_HI:0];
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign o_lane_ctrl = ctrl_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // automatic quiet: mute is the inverse of signal presence one cycle later
   chk_quiet_auto_mute: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && $past(regs_q[LCR_IDX_DETECT][LCR_QUIET_AUTO_BIT])
      |-> (o_lane_ctrl.output_muted == !$past(i_signal_present)) && o_lane_ctrl.detector_enable)
      else $error("automatic quiet mute mismatch");

   // manual quiet: mute follows select bit, detector off
   chk_manual_quiet_mute: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $past(i_reset_n) && !$past(regs_q[LCR_IDX_DETECT][LCR_QUIET_AUTO_BIT])
      |-> (o_lane_ctrl.output_muted == $past(regs_q[LCR_IDX_DETECT][LCR_QUIET_SEL_BIT]))
          && !o_lane_ctrl.detector_enable)
      else $error("manual quiet mute mismatch");

   // a write of manual quiet with mute reaches the lane two edges later
   chk_manual_mute_write: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_bus.wr && (i_bus.addr == LCR_ADDR_DETECT)
      && !i_bus.wdata[LCR_QUIET_AUTO_BIT] && i_bus.wdata[LCR_QUIET_SEL_BIT]
      ##1 !(i_bus.wr && (i_bus.addr == LCR_ADDR_DETECT))
      |-> ##1 o_lane_ctrl.output_muted)
      else $error("forced mute not applied");

   // rate selection, automatic or forced
   chk_rate_select: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $past(i_reset_n)
      |-> o_lane_ctrl.rate_5g == ($past(regs_q[LCR_IDX_DETECT][LCR_RATE_AUTO_BIT])
          ? $past(i_rate_detected_5g) : $past(regs_q[LCR_IDX_DETECT][LCR_RATE_SEL_BIT])))
      else $error("rate selection mismatch");

   // equalizer field split: enable, gain stage, boost
   chk_eq_fields: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $past(i_reset_n)
      |-> {o_lane_ctrl.eq_enable, o_lane_ctrl.gain_stage_field, o_lane_ctrl.boost_level_field}
          == $past(regs_q[LCR_IDX_EQ][LCR_EQ_EN_BIT:0]))
      else $error("equalizer field mismatch");

   // equalizer level index never exceeds the documented count when gain is below 3
   chk_eq_levels: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_lane_ctrl.gain_stage_field != 2'h3)
      |-> ({o_lane_ctrl.gain_stage_field, o_lane_ctrl.boost_level_field} < LCR_EQ_LEVELS))
      else $error("equalizer level out of range");

   // after reset the equalizer reads bypass unless a strap seeds it
   chk_eq_reset_bypass: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      !$past(i_reset_n) |-> regs_q[LCR_IDX_EQ] == {2'h0, LCR_EQ_BYPASS})
      else $error("equalizer reset value wrong");

   // strap seeding of equalizer and de-emphasis on the first edge after release
   chk_strap_seed: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      strap_load && !i_bus.wr && strap_eq_valid
      |=> regs_q[LCR_IDX_EQ] == {2'h0, $past(strap_eq_code)})
      else $error("equalizer strap not loaded");

   chk_strap_deemph: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      strap_load && !i_bus.wr && strap_deemph_valid
      |=> regs_q[LCR_IDX_DEEMPH] == $past(strap_deemph_code))
      else $error("de-emphasis strap not loaded");

   // swing register resets to the 600 mV code
   chk_swing_reset: assert property (@(posedge i_sys_clk)
      !$past(i_reset_n) |=> o_lane_ctrl.output_swing_field == LCR_SWING_600MV)
      else $error("swing reset value wrong");

   // swing write reaches the driver two edges later
   chk_swing_write: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_bus.wr && (i_bus.addr == LCR_ADDR_SWING)
      ##1 !(i_bus.wr && (i_bus.addr == LCR_ADDR_SWING))
      |-> ##1 o_lane_ctrl.output_swing_field == $past(i_bus.wdata[LCR_SWING_HI:0], 2))
      else $error("swing write not applied");

   // de-emphasis style and level follow the register
   chk_deemph_fields: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $past(i_reset_n)
      |-> {o_lane_ctrl.deemphasis_style, o_lane_ctrl.deemph_level}
          == $past(regs_q[LCR_IDX_DEEMPH]))
      else $error("de-emphasis field mismatch");

   // threshold pairs follow the register
   chk_thresh_fields: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $past(i_reset_n)
      |-> {o_lane_ctrl.quiet_deassert_thr, o_lane_ctrl.quiet_assert_thr}
          == $past(regs_q[LCR_IDX_THRESH][LCR_THR_DEASSERT_HI:0]))
      else $error("threshold field mismatch");

   // threshold reset is the 110/70 mV default pair
   chk_thresh_reset: assert property (@(posedge i_sys_clk)
      !$past(i_reset_n) |=> (o_lane_ctrl.quiet_deassert_thr == 2'h0)
                          && (o_lane_ctrl.quiet_assert_thr == 2'h0))
      else $error("threshold reset value wrong");

   // read answer stands one cycle after the strobe and is zero otherwise
   chk_read_timing: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      !i_bus.rd |=> o_rdata == 8'h00)
      else $error("read data outside answer cycle");

   chk_read_value: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      i_bus.rd && (i_bus.addr == LCR_ADDR_THRESH)
      |=> o_rdata == $past(regs_q[LCR_IDX_THRESH]))
      else $error("threshold read data wrong");

   // reserved detect bits always read back as zero
   chk_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (regs_q[LCR_IDX_DETECT] & ~LCR_MASK_DETECT) == 8'h00)
      else $error("reserved bits stored");

endmodule // lcr_lane_regs
`default_nettype wire

/* pkg/lcr_pkg.sv */
// constants, register map and carrier types for the lane conditioning registers
package lcr_pkg;

   // register map: one byte-wide register per entry
   localparam int LCR_NUM_REGS = 5;
   localparam int LCR_IDX_DETECT = 0;
   localparam int LCR_IDX_EQ = 1;
   localparam int LCR_IDX_SWING = 2;
   localparam int LCR_IDX_DEEMPH = 3;
   localparam int LCR_IDX_THRESH = 4;

   localparam logic [7:0] LCR_ADDR_DETECT = 8'h39;
   localparam logic [7:0] LCR_ADDR_EQ = 8'h3a;
   localparam logic [7:0] LCR_ADDR_SWING = 8'h3b;
   localparam logic [7:0] LCR_ADDR_DEEMPH = 8'h3c;
   localparam logic [7:0] LCR_ADDR_THRESH = 8'h3d;

   localparam logic [7:0] LCR_RST_DETECT = 8'h00;
   localparam logic [7:0] LCR_RST_EQ = 8'h20;
   localparam logic [7:0] LCR_RST_SWING = 8'h03;
   localparam logic [7:0] LCR_RST_DEEMPH = 8'h03;
   localparam logic [7:0] LCR_RST_THRESH = 8'h00;

   // writable bits; reserved bits are stored as zero and read as zero
   localparam logic [7:0] LCR_MASK_DETECT = 8'h33;
   localparam logic [7:0] LCR_MASK_EQ = 8'h3f;
   localparam logic [7:0] LCR_MASK_SWING = 8'h3f;
   localparam logic [7:0] LCR_MASK_DEEMPH = 8'hff;
   localparam logic [7:0] LCR_MASK_THRESH = 8'h0f;

   localparam logic [7:0] LCR_ADDR_TBL [LCR_NUM_REGS] = '{LCR_ADDR_DETECT, LCR_ADDR_EQ,
      LCR_ADDR_SWING, LCR_ADDR_DEEMPH, LCR_ADDR_THRESH};
   localparam logic [7:0] LCR_RST_TBL [LCR_NUM_REGS] = '{LCR_RST_DETECT, LCR_RST_EQ,
      LCR_RST_SWING, LCR_RST_DEEMPH, LCR_RST_THRESH};
   localparam logic [7:0] LCR_MASK_TBL [LCR_NUM_REGS] = '{LCR_MASK_DETECT, LCR_MASK_EQ,
      LCR_MASK_SWING, LCR_MASK_DEEMPH, LCR_MASK_THRESH};

   // detect/select register fields
   localparam int LCR_QUIET_AUTO_BIT = 5;
   localparam int LCR_QUIET_SEL_BIT = 4;
   localparam int LCR_RATE_AUTO_BIT = 1;
   localparam int LCR_RATE_SEL_BIT = 0;

   // equalizer fields: 3 gain stages x 8 boost settings = 24 levels
   localparam int LCR_EQ_EN_BIT = 5;
   localparam int LCR_EQ_GAIN_HI = 4;
   localparam int LCR_EQ_GAIN_LO = 3;
   localparam int LCR_EQ_BOOST_HI = 2;
   localparam int LCR_EQ_BOOST_LO = 0;
   localparam int LCR_EQ_LEVELS = 24;
   localparam logic [5:0] LCR_EQ_BYPASS = 6'h20;

   // swing field and its documented codes
   localparam int LCR_SWING_HI = 5;
   localparam logic [5:0] LCR_SWING_600MV = 6'h03;
   localparam logic [5:0] LCR_SWING_800MV = 6'h07;
   localparam logic [5:0] LCR_SWING_1000MV = 6'h0f;

   // de-emphasis fields and codes
   localparam int LCR_DEEMPH_STYLE_BIT = 7;
   localparam int LCR_DEEMPH_LEVEL_HI = 6;
   localparam logic [7:0] LCR_DEEMPH_0DB = 8'h01;
   localparam logic [7:0] LCR_DEEMPH_3P5DB = 8'he8;
   localparam logic [7:0] LCR_DEEMPH_6DB = 8'h88;
   localparam logic [7:0] LCR_DEEMPH_9DB = 8'h90;
   localparam logic [7:0] LCR_DEEMPH_12DB = 8'ha0;
   localparam logic [7:0] LCR_DEEMPH_RSVD = 8'hc0;

   // quiet threshold fields: deassert pair high, assert pair low
   localparam int LCR_THR_DEASSERT_HI = 3;
   localparam int LCR_THR_DEASSERT_LO = 2;
   localparam int LCR_THR_ASSERT_HI = 1;
   localparam int LCR_THR_ASSERT_LO = 0;

   // three-level strap pin reading
   localparam logic [1:0] LCR_STRAP_LOW = 2'h0;
   localparam logic [1:0] LCR_STRAP_HIGH = 2'h1;
   localparam logic [1:0] LCR_STRAP_FLOAT = 2'h2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lcr_bus_req_t;

   typedef struct packed {
      logic [1:0] equalizer_strap_high;
      logic [1:0] equalizer_strap_low;
      logic [1:0] deemphasis_strap_high;
      logic [1:0] deemphasis_strap_low;
   } lcr_strap_t;

   typedef struct packed {
      logic detector_enable;
      logic output_muted;
      logic rate_auto;
      logic rate_5g;
      logic eq_enable;
      logic [1:0] gain_stage_field;
      logic [2:0] boost_level_field;
      logic [5:0] output_swing_field;
      logic deemphasis_style;
      logic [6:0] deemph_level;
      logic [1:0] quiet_deassert_thr;
      logic [1:0] quiet_assert_thr;
   } lcr_lane_ctrl_t;

endpackage

/* hdl/lcr_strap_decode.sv */
// strap pin to register code translation for equalizer and de-emphasis
`timescale 1ns/1ps
`default_nettype none
module lcr_strap_decode
   import lcr_pkg::*;
(
   input wire lcr_strap_t i_strap,
   output logic [5:0] o_eq_code,
   output logic o_eq_valid,
   output logic [7:0] o_deemph_code,
   output logic o_deemph_valid
);

   // equalizer: {high, low} pin pair selects one register code
   always_comb begin
      o_eq_valid = 1'b1;
      case ({i_strap.equalizer_strap_high, i_strap.equalizer_strap_low})
         {LCR_STRAP_FLOAT, LCR_STRAP_FLOAT}: o_eq_code = LCR_EQ_BYPASS;
         {LCR_STRAP_HIGH, LCR_STRAP_HIGH}: o_eq_code = 6'h2a;
         {LCR_STRAP_LOW, LCR_STRAP_LOW}: o_eq_code = 6'h30;
         {LCR_STRAP_FLOAT, LCR_STRAP_LOW}: o_eq_code = 6'h32;
         {LCR_STRAP_HIGH, LCR_STRAP_LOW}: o_eq_code = 6'h39;
         {LCR_STRAP_FLOAT, LCR_STRAP_HIGH}: o_eq_code = 6'h35;
         {LCR_STRAP_LOW, LCR_STRAP_HIGH}: o_eq_code = 6'h37;
         {LCR_STRAP_LOW, LCR_STRAP_FLOAT}: o_eq_code = 6'h3b;
         {LCR_STRAP_HIGH, LCR_STRAP_FLOAT}: o_eq_code = 6'h3d;
         default: begin
            o_eq_code = LCR_EQ_BYPASS;
            o_eq_valid = 1'b0;
         end
      endcase
   end

   // de-emphasis: {high, low} pin pair; reserved setting leaves the register alone
   always_comb begin
      o_deemph_valid = 1'b1;
      case ({i_strap.deemphasis_strap_high, i_strap.deemphasis_strap_low})
         {LCR_STRAP_LOW, LCR_STRAP_LOW}: o_deemph_code = LCR_DEEMPH_0DB;
         {LCR_STRAP_LOW, LCR_STRAP_HIGH}: o_deemph_code = LCR_DEEMPH_3P5DB;
         {LCR_STRAP_HIGH, LCR_STRAP_HIGH}: o_deemph_code = LCR_DEEMPH_6DB;
         {LCR_STRAP_LOW, LCR_STRAP_FLOAT}: o_deemph_code = LCR_DEEMPH_9DB;
         {LCR_STRAP_HIGH, LCR_STRAP_FLOAT}: o_deemph_code = LCR_DEEMPH_12DB;
         {LCR_STRAP_FLOAT, LCR_STRAP_LOW}: o_deemph_code = LCR_DEEMPH_9DB;
         {LCR_STRAP_FLOAT, LCR_STRAP_HIGH}: o_deemph_code = LCR_DEEMPH_12DB;
         default: begin
            o_deemph_code = LCR_RST_DEEMPH;
            o_deemph_valid = 1'b0;
         end
      endcase
   end

endmodule // lcr_strap_decode
`default_nettype wire

/* testbench/lcr_lane_regs_tb.sv */
// self-checking testbench for the lane conditioning register bank
`timescale 1ns/1ps
`default_nettype none
module lcr_lane_regs_tb
   import lcr_pkg::*;
;
   logic i_sys_clk;
   logic i_reset_n;
   lcr_bus_req_t i_bus;
   logic [7:0] o_rdata;
   lcr_strap_t i_strap;
   logic i_signal_present;
   logic i_rate_detected_5g;
   lcr_lane_ctrl_t o_lane_ctrl;
   int failures = 0;
   int n_checks = 0;

   lcr_lane_regs dut (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_bus(i_bus),
      .o_rdata(o_rdata),
      .i_strap(i_strap),
      .i_signal_present(i_signal_present),
      .i_rate_detected_5g(i_rate_detected_5g),
      .o_lane_ctrl(o_lane_ctrl)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // clock, time-zero values and watchdog
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end

   initial begin
      i_reset_n = 1'b0;
      i_bus = '0;
      i_strap = 8'haa;
      i_signal_present = 1'b0;
      i_rate_detected_5g = 1'b0;
   end

   // the whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      failures++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // reset held 20 cycles with the given strap setting, then three edges for the seed
   task automatic do_reset(input logic [7:0] strap);
      @(posedge i_sys_clk);
      i_reset_n <= 1'b0;
      i_bus <= '0;
      i_strap <= strap;
      repeat (20) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
   endtask

   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_sys_clk);
      i_bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge i_sys_clk);
      i_bus <= '0;
   endtask

   // read data stand in the single cycle after the strobe, then fall to zero
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_sys_clk);
      i_bus <= '0;
      #1;
      chk("read data", o_rdata, exp);
      @(posedge i_sys_clk);
      #1;
      chk("read data idle", o_rdata, 8'h00);
   endtask

   // lets a register update reach the lane control outputs
   task automatic settle();
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset_values();
      do_reset(8'haa);
      rd_chk(LCR_ADDR_DETECT, 8'h00);
      rd_chk(LCR_ADDR_EQ, 8'h20);
      rd_chk(LCR_ADDR_SWING, 8'h03);
      rd_chk(LCR_ADDR_DEEMPH, 8'h03);
      rd_chk(LCR_ADDR_THRESH, 8'h00);
      #1;
      chk("eq enable at reset", o_lane_ctrl.eq_enable, 1'b1);
      chk("eq gain at reset", o_lane_ctrl.gain_stage_field, 2'h0);
      chk("swing at reset", o_lane_ctrl.output_swing_field, 6'h03);
      chk("thresholds at reset", {o_lane_ctrl.quiet_deassert_thr, o_lane_ctrl.quiet_assert_thr},
         4'h0);
      $display("test reset values done");
   endtask

   // every defined bit set then all zeros, plus unmapped neighbours; reserved bits are never written with ones
   task automatic t_readback();
      logic [7:0] masks [5] = '{8'h33, 8'h3f, 8'h3f, 8'hff, 8'h0f};
      for (int i = 0; i < 5; i++) begin
         wr_reg(8'h39 + 8'(i), masks[i]);
         rd_chk(8'h39 + 8'(i), masks[i]);
         wr_reg(8'h39 + 8'(i), 8'h00);
         rd_chk(8'h39 + 8'(i), 8'h00);
      end
      wr_reg(8'h38, 8'h5a);
      wr_reg(8'h3e, 8'ha5);
      rd_chk(8'h38, 8'h00);
      rd_chk(8'h3e, 8'h00);
      $display("test readback done");
   endtask

   // rows: setting, signal present, rate detected, then enable/mute/auto-rate/5g expected
   task automatic t_quiet_rate();
      logic [13:0] rows [9] = '{{8'h00, 2'b11, 4'b0000}, {8'h10, 2'b10, 4'b0100},
         {8'h01, 2'b00, 4'b0001}, {8'h20, 2'b10, 4'b1000}, {8'h20, 2'b00, 4'b1100},
         {8'h22, 2'b11, 4'b1011}, {8'h22, 2'b10, 4'b1010}, {8'h30, 2'b10, 4'b1000},
         {8'h03, 2'b00, 4'b0010}};
      for (int i = 0; i < 9; i++) begin
         @(posedge i_sys_clk);
         i_signal_present <= rows[i][5];
         i_rate_detected_5g <= rows[i][4];
         wr_reg(LCR_ADDR_DETECT, rows[i][13:6]);
         settle();
         chk("quiet detect enable", o_lane_ctrl.detector_enable, rows[i][3]);
         chk("output muted", o_lane_ctrl.output_muted, rows[i][2]);
         chk("rate auto", o_lane_ctrl.rate_auto, rows[i][1]);
         chk("rate 5g", o_lane_ctrl.rate_5g, rows[i][0]);
      end
      // auto quiet follows the detector while the register stays put
      wr_reg(LCR_ADDR_DETECT, 8'h20);
      settle();
      chk("muted without signal", o_lane_ctrl.output_muted, 1'b1);
      @(posedge i_sys_clk);
      i_signal_present <= 1'b1;
      settle();
      chk("muted follows detector", o_lane_ctrl.output_muted, 1'b0);
      $display("test quiet and rate done");
   endtask

   task automatic t_fields();
      logic [7:0] eqv [3] = '{8'h2a, 8'h1f, 8'h3b};
      logic [7:0] swv [3] = '{8'h03, 8'h07, 8'h0f};
      logic [7:0] dev [5] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0};
      logic [7:0] thv [2] = '{8'h0e, 8'h0b};
      for (int i = 0; i < 3; i++) begin
         wr_reg(LCR_ADDR_EQ, eqv[i]);
         wr_reg(LCR_ADDR_SWING, swv[i]);
         settle();
         chk("eq enable", o_lane_ctrl.eq_enable, eqv[i][5]);
         chk("gain stage", o_lane_ctrl.gain_stage_field, eqv[i][4:3]);
         chk("boost level", o_lane_ctrl.boost_level_field, eqv[i][2:0]);
         chk("swing", o_lane_ctrl.output_swing_field, swv[i][5:0]);
      end
      for (int i = 0; i < 5; i++) begin
         wr_reg(LCR_ADDR_DEEMPH, dev[i]);
         settle();
         chk("deemph style", o_lane_ctrl.deemphasis_style, dev[i][7]);
         chk("deemph level", o_lane_ctrl.deemph_level, dev[i][6:0]);
      end
      for (int i = 0; i < 2; i++) begin
         wr_reg(LCR_ADDR_THRESH, thv[i]);
         settle();
         chk("deassert thr", o_lane_ctrl.quiet_deassert_thr, thv[i][3:2]);
         chk("assert thr", o_lane_ctrl.quiet_assert_thr, thv[i][1:0]);
      end
      $display("test field decode done");
   endtask

   // strap byte is eq high, eq low, deemph high, deemph low; 2 means floating
   task automatic t_straps();
      logic [7:0] strap [9] = '{8'ha0, 8'h51, 8'h05, 8'h82, 8'h46, 8'h98, 8'h19, 8'h2a, 8'h64};
      logic [7:0] eqx [9] = '{8'h20, 8'h2a, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3b, 8'h3d};
      logic [7:0] dex [9] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0, 8'h90, 8'ha0, 8'h03, 8'h03};
      for (int i = 0; i < 9; i++) begin
         do_reset(strap[i]);
         rd_chk(LCR_ADDR_EQ, eqx[i]);
         rd_chk(LCR_ADDR_DEEMPH, dex[i]);
         chk("strap eq boost", o_lane_ctrl.boost_level_field, eqx[i][2:0]);
      end
      $display("test strap seeding done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and main sequence
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      t_reset_values();
      t_readback();
      t_quiet_rate();
      t_fields();
      t_straps();
      close_out();
   end
endmodule // lcr_lane_regs_tb
`default_nettype wire
